/* File: bps_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module bps_ctrl #(
	parameter int LEVELS = bps_pkg::SPEC_LEVELS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire bps_pkg::bps_fetch_s fetch_i,
	input wire bps_pkg::bps_dec_s dec_i,
	input wire bps_pkg::bps_res_s res_i,
	input wire logic fp_done,
	input wire logic exc_fault,
	input wire logic wbuf_full,
	output logic [bps_pkg::AW-1:0] fetch_pc_r,
	output logic fetch_pred_taken_r,
	output logic [bps_pkg::AW-1:0] fetch_alt_pc_r,
	output logic fetch_alt_vld_r,
	output logic fetch_hold_r,
	output logic issue_x_only_r,
	output logic spec_stall_r,
	output logic [2:0] spec_level_r,
	output logic ckpt_save_r,
	output logic [1:0] ckpt_slot_r,
	output logic restore_r,
	output logic [1:0] restore_slot_r,
	output logic flush_r,
	output logic br_ok_r,
	output logic wr_hold_r
);
	localparam int SLW = $clog2(LEVELS);

	// Ring pointers wrap by width and the two-bit slot ports hold at most four
	if (LEVELS < 2 || LEVELS > 4 || (1 << SLW) != LEVELS) begin
		$error("bps_ctrl: LEVELS must be 2 or 4");
	end

	// ------------------------------------------------------------
	// Prediction sources
	// ------------------------------------------------------------
	logic btb_hit, btb_tk, ras_vld;
	logic [bps_pkg::AW-1:0] btb_tgt, ras_top;
	logic [bps_pkg::AW-1:0] pr_pc, alt_pc;
	logic pr_tk, alt_v;

	bps_btb bps_btb_i (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.lk_pc(fetch_i.pc),
		.lk_hit(btb_hit),
		.lk_target(btb_tgt),
		.lk_taken(btb_tk),
		.up_valid(res_i.valid),
		.up_taken(res_i.taken),
		.up_pc(res_i.pc),
		.up_target(res_i.target)
	);

	bps_ras bps_ras_i (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.push(fetch_i.valid && fetch_i.is_call),
		.pop(fetch_i.valid && fetch_i.is_ret),
		.push_pc(fetch_i.seq_pc),
		.top_vld(ras_vld),
		.top_pc(ras_top)
	);

	// Next fetch address; returns with a valid stack top bypass the target buffer
	always_comb begin
		pr_pc = fetch_i.seq_pc;
		pr_tk = 1'b0;
		alt_v = 1'b0;
		alt_pc = fetch_i.seq_pc;
		if (fetch_i.is_ret && ras_vld) begin
			pr_pc = ras_top;
			pr_tk = 1'b1;
		end else if (fetch_i.is_br && btb_hit && (!fetch_i.is_cond || btb_tk)) begin
			pr_pc = btb_tgt;
			pr_tk = 1'b1;
		end
		if (fetch_i.is_br && fetch_i.is_cond && btb_hit) begin
			alt_v = 1'b1;
			alt_pc = pr_tk ? fetch_i.seq_pc : btb_tgt;
		end
	end

	// ------------------------------------------------------------
	// Checkpoint ring and speculation level
	// ------------------------------------------------------------
	logic slot_tk_r [LEVELS];
	logic [bps_pkg::AW-1:0] slot_pc_r [LEVELS];
	logic [SLW-1:0] head_r, tail_r;
	logic [2:0] level_nxt;
	logic alloc, stop, res_ok, mis, fp_free;
	logic [bps_pkg::AW-1:0] good_pc;
	logic [bps_pkg::PEN_W-1:0] pen_r, pen_nxt;

	// Any stop condition keeps new levels from opening
	always_comb begin
		stop = exc_fault || wbuf_full || (dec_i.valid && dec_i.nonckpt);
		if (dec_i.valid && (dec_i.is_cbr || dec_i.is_fp) && spec_level_r == 3'(LEVELS)) begin
			stop = 1'b1;
		end
	end

	// Resolution against the oldest open checkpoint only
	always_comb begin
		res_ok = res_i.valid && spec_level_r != '0;
		good_pc = res_i.taken ? res_i.target : res_i.seq_pc;
		mis = res_ok && (res_i.taken != slot_tk_r[head_r] ||
			(res_i.taken && res_i.target != slot_pc_r[head_r]));
		// A float completion beside a branch frees a second slot, so no level leaks
		fp_free = fp_done && spec_level_r > 3'(res_ok);
		alloc = dec_i.valid && (dec_i.is_cbr || dec_i.is_fp) && !stop && !mis;
	end

	// Level: flush on mispredict, else +alloc -free
	always_comb begin
		level_nxt = spec_level_r;
		if (mis) begin
			level_nxt = '0;
		end else begin
			level_nxt = spec_level_r + 3'(alloc) - 3'(res_ok) - 3'(fp_free);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			spec_level_r <= '0;
			head_r <= '0;
			tail_r <= '0;
		end else begin
			spec_level_r <= level_nxt;
			if (mis) begin
				tail_r <= head_r;
			end else begin
				if (alloc) begin
					tail_r <= tail_r + 1'b1;
				end
				head_r <= head_r + SLW'(res_ok) + SLW'(fp_free);
			end
		end
	end

	// Checkpoint payload: predicted direction and address
	always_ff @(posedge core_clk) begin
		if (alloc) begin
			slot_tk_r[tail_r] <= dec_i.is_cbr && dec_i.pred_taken;
			slot_pc_r[tail_r] <= dec_i.pred_pc;
		end
	end

	// Checkpoint strobes toward the register file
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ckpt_save_r <= 1'b0;
			ckpt_slot_r <= '0;
			restore_r <= 1'b0;
			restore_slot_r <= '0;
			flush_r <= 1'b0;
			br_ok_r <= 1'b0;
		end else begin
			ckpt_save_r <= alloc;
			ckpt_slot_r <= 2'(tail_r);
			restore_r <= mis;
			restore_slot_r <= 2'(head_r);
			flush_r <= mis;
			br_ok_r <= res_ok && !mis;
		end
	end

	// ------------------------------------------------------------
	// Fetch redirect and recovery penalty
	// ------------------------------------------------------------
	always_comb begin
		pen_nxt = pen_r;
		if (mis) begin
			pen_nxt = res_i.in_wb ? bps_pkg::PEN_W'(bps_pkg::PEN_WB_CYC) :
				bps_pkg::PEN_W'(bps_pkg::PEN_EX_CYC);
		end else if (pen_r != '0) begin
			pen_nxt = pen_r - 1'b1;
		end
	end

	// Redirect beats prediction; alternate path rides with it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_pc_r <= bps_pkg::PC_RST;
			fetch_pred_taken_r <= 1'b0;
			fetch_alt_pc_r <= '0;
			fetch_alt_vld_r <= 1'b0;
			pen_r <= '0;
			fetch_hold_r <= 1'b0;
		end else begin
			pen_r <= pen_nxt;
			fetch_hold_r <= pen_nxt != '0;
			if (mis) begin
				fetch_pc_r <= good_pc;
				fetch_pred_taken_r <= 1'b0;
				fetch_alt_vld_r <= 1'b0;
			end else if (fetch_i.valid) begin
				fetch_pc_r <= pr_pc;
				fetch_pred_taken_r <= pr_tk;
				fetch_alt_pc_r <= alt_pc;
				fetch_alt_vld_r <= alt_v;
			end else begin
				fetch_alt_vld_r <= 1'b0;
			end
		end
	end

	// Issue steering, stop flag and write hold
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			issue_x_only_r <= 1'b0;
			spec_stall_r <= 1'b0;
			wr_hold_r <= 1'b0;
		end else begin
			issue_x_only_r <= dec_i.valid && dec_i.is_cbr;
			spec_stall_r <= stop;
			wr_hold_r <= level_nxt != '0;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_level_max;
		@(posedge core_clk) disable iff (!rst_n) spec_level_r <= 3'(LEVELS);
	endproperty
	a_level_max: assert property (p_level_max) else $error("level above max");

	property p_alloc_inc;
		@(posedge core_clk) disable iff (!rst_n)
		alloc && !res_ok && !fp_free |=> spec_level_r == $past(spec_level_r) + 3'd1;
	endproperty
	a_alloc_inc: assert property (p_alloc_inc) else $error("level not raised");

	property p_ok_one;
		@(posedge core_clk) disable iff (!rst_n)
		res_ok && !mis |=> br_ok_r && !flush_r && spec_level_r < 3'(LEVELS);
	endproperty
	a_ok_one: assert property (p_ok_one) else $error("correct branch slow");

	property p_pen_ex;
		@(posedge core_clk) disable iff (!rst_n)
		mis && !res_i.in_wb |=> fetch_hold_r [*4] ##1 !fetch_hold_r;
	endproperty
	a_pen_ex: assert property (p_pen_ex) else $error("execute penalty not 4");

	property p_pen_wb;
		@(posedge core_clk) disable iff (!rst_n)
		mis && res_i.in_wb |=> fetch_hold_r [*5] ##1 !fetch_hold_r;
	endproperty
	a_pen_wb: assert property (p_pen_wb) else $error("writeback penalty not 5");

	property p_restore;
		@(posedge core_clk) disable iff (!rst_n)
		mis |=> restore_r && flush_r && spec_level_r == '0 && fetch_pc_r == $past(good_pc);
	endproperty
	a_restore: assert property (p_restore) else $error("restore late");

	property p_stop_full;
		@(posedge core_clk) disable iff (!rst_n)
		dec_i.valid && dec_i.is_fp && spec_level_r == 3'(LEVELS) |=> spec_stall_r && !ckpt_save_r;
	endproperty
	a_stop_full: assert property (p_stop_full) else $error("no stop at full");

	property p_wr_hold;
		@(posedge core_clk) disable iff (!rst_n) (spec_level_r != '0) == wr_hold_r;
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write hold wrong");

	property p_x_only;
		@(posedge core_clk) disable iff (!rst_n) dec_i.valid && dec_i.is_cbr |=> issue_x_only_r;
	endproperty
	a_x_only: assert property (p_x_only) else $error("branch not x only");

	property p_no_under;
		@(posedge core_clk) disable iff (!rst_n)
		spec_level_r == '0 && !alloc |=> spec_level_r == '0 && !br_ok_r;
	endproperty
	a_no_under: assert property (p_no_under) else $error("level underflow");

	property p_fp_free;
		@(posedge core_clk) disable iff (!rst_n)
		fp_free && !alloc && !mis |=>
		spec_level_r == $past(spec_level_r) - 3'd1 - 3'($past(res_ok));
	endproperty
	a_fp_free: assert property (p_fp_free) else $error("float not freed");

	c_mis_wb: cover property (@(posedge core_clk) disable iff (!rst_n) mis && res_i.in_wb);
	c_full: cover property (@(posedge core_clk) disable iff (!rst_n) spec_level_r == 3'(LEVELS));
	c_ok: cover property (@(posedge core_clk) disable iff (!rst_n) res_ok && !mis);
endmodule
`default_nettype wire

/* File: bps_pkg.sv */
package bps_pkg;
	// ------------------------------------------------------------
	// Sizes and timing counts
	// ------------------------------------------------------------
	localparam int AW = 32;
	localparam int BTB_ENTRIES = 512;
	localparam int BTB_WAYS = 4;
	localparam int BHT_ENTRIES = 1024;
	localparam int RAS_DEPTH = 8;
	localparam int SPEC_LEVELS = 4;
	localparam int PEN_EX_CYC = 4;
	localparam int PEN_WB_CYC = 5;
	localparam int PEN_W = 3;
	// Address fields: word aligned branch addresses
	localparam int SET_LSB = 2;
	localparam int BHT_LSB = 2;
	localparam logic [31:0] PC_RST = 32'hfffffff0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	// Four-state direction counter
	typedef enum logic [1:0] {
		CTR_STRONG_NT,
		CTR_WEAK_NT,
		CTR_WEAK_T,
		CTR_STRONG_T
	} bps_ctr_e;

	typedef struct packed {
		logic valid;
		logic [AW-1:0] pc;
		logic [AW-1:0] seq_pc;
		logic is_br;
		logic is_cond;
		logic is_call;
		logic is_ret;
	} bps_fetch_s;

	typedef struct packed {
		logic valid;
		logic is_cbr;
		logic is_fp;
		logic nonckpt;
		logic pred_taken;
		logic [AW-1:0] pred_pc;
	} bps_dec_s;

	typedef struct packed {
		logic valid;
		logic taken;
		logic in_wb;
		logic [AW-1:0] pc;
		logic [AW-1:0] target;
		logic [AW-1:0] seq_pc;
	} bps_res_s;

	// Saturating counter step
	function automatic bps_ctr_e bps_ctr_step(bps_ctr_e c, logic tk);
		bps_ctr_step = c;
		if (tk && c != CTR_STRONG_T) begin
			bps_ctr_step = bps_ctr_e'(c + 2'd1);
		end else if (!tk && c != CTR_STRONG_NT) begin
			bps_ctr_step = bps_ctr_e'(c - 2'd1);
		end
	endfunction
endpackage

/* File: bps_btb.sv */
`timescale 1ns/10ps
`default_nettype none
module bps_btb #(
	parameter int ENTRIES = bps_pkg::BTB_ENTRIES,
	parameter int WAYS = bps_pkg::BTB_WAYS,
	parameter int HIST = bps_pkg::BHT_ENTRIES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [bps_pkg::AW-1:0] lk_pc,
	output logic lk_hit,
	output logic [bps_pkg::AW-1:0] lk_target,
	output logic lk_taken,
	input wire logic up_valid,
	input wire logic up_taken,
	input wire logic [bps_pkg::AW-1:0] up_pc,
	input wire logic [bps_pkg::AW-1:0] up_target
);
	localparam int SETS = ENTRIES / WAYS;
	localparam int SW = $clog2(SETS);
	localparam int HW = $clog2(HIST);
	localparam int TL = bps_pkg::SET_LSB + SW;
	localparam int WW = $clog2(WAYS);

	// Index slicing only serves power-of-two sets and history depth
	if (SETS * WAYS != ENTRIES || (1 << SW) != SETS || (1 << HW) != HIST) begin
		$error("bps_btb: sizes must be powers of two");
	end

	logic [bps_pkg::AW-1:TL] tag_r [SETS][WAYS];
	logic [bps_pkg::AW-1:0] tgt_r [SETS][WAYS];
	logic vld_r [SETS][WAYS];
	bps_pkg::bps_ctr_e bht_r [HIST];
	logic [WW-1:0] rr_r;
	logic [SW-1:0] lk_set, up_set;
	logic up_hit;
	logic [WW-1:0] up_way;

	assign lk_set = lk_pc[TL-1:bps_pkg::SET_LSB];
	assign up_set = up_pc[TL-1:bps_pkg::SET_LSB];

	// ------------------------------------------------------------
	// Lookup: target from the buffer, direction from history
	// ------------------------------------------------------------
	always_comb begin
		lk_hit = 1'b0;
		lk_target = '0;
		up_hit = 1'b0;
		up_way = rr_r;
		for (int w = 0; w < WAYS; w++) begin
			if (vld_r[lk_set][w] && tag_r[lk_set][w] == lk_pc[bps_pkg::AW-1:TL]) begin
				lk_hit = 1'b1;
				lk_target = tgt_r[lk_set][w];
			end
			if (vld_r[up_set][w] && tag_r[up_set][w] == up_pc[bps_pkg::AW-1:TL]) begin
				up_hit = 1'b1;
				up_way = WW'(w);
			end
		end
		lk_taken = bht_r[lk_pc[HW+bps_pkg::BHT_LSB-1:bps_pkg::BHT_LSB]][1];
	end

	// Taken branches allocate; round robin victim keeps it cheap
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rr_r <= '0;
			for (int s = 0; s < SETS; s++) begin
				for (int w = 0; w < WAYS; w++) begin
					vld_r[s][w] <= 1'b0;
				end
			end
		end else if (up_valid && up_taken) begin
			vld_r[up_set][up_way] <= 1'b1;
			if (!up_hit) begin
				rr_r <= rr_r + 1'b1;
			end
		end
	end

	// Tag and target storage, no reset needed behind valid
	always_ff @(posedge core_clk) begin
		if (up_valid && up_taken) begin
			tag_r[up_set][up_way] <= up_pc[bps_pkg::AW-1:TL];
			tgt_r[up_set][up_way] <= up_target;
		end
	end

	// History counters train on every resolution
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < HIST; i++) begin
				bht_r[i] <= bps_pkg::CTR_WEAK_NT;
			end
		end else if (up_valid) begin
			bht_r[up_pc[HW+bps_pkg::BHT_LSB-1:bps_pkg::BHT_LSB]] <=
				bps_pkg::bps_ctr_step(bht_r[up_pc[HW+bps_pkg::BHT_LSB-1:bps_pkg::BHT_LSB]], up_taken);
		end
	end
endmodule
`default_nettype wire

/* File: bps_ras.sv */
`timescale 1ns/10ps
`default_nettype none
module bps_ras #(
	parameter int DEPTH = bps_pkg::RAS_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [bps_pkg::AW-1:0] push_pc,
	output logic top_vld,
	output logic [bps_pkg::AW-1:0] top_pc
);
	localparam int PW = $clog2(DEPTH);

	// Pointer wraps by width, so the depth must be a power of two
	if ((1 << PW) != DEPTH || DEPTH < 2) begin
		$error("bps_ras: depth must be a power of two");
	end

	logic [bps_pkg::AW-1:0] stk_r [DEPTH];
	logic [PW-1:0] sp_r;
	logic [PW:0] cnt_r;

	assign top_vld = cnt_r != '0;
	assign top_pc = stk_r[sp_r - 1'b1];

	// ------------------------------------------------------------
	// Circular stack: deep call chains overwrite the oldest entry
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_r <= '0;
			cnt_r <= '0;
		end else if (push) begin
			sp_r <= sp_r + 1'b1;
			if (cnt_r != (PW+1)'(DEPTH)) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end else if (pop && top_vld) begin
			sp_r <= sp_r - 1'b1;
			cnt_r <= cnt_r - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			stk_r[sp_r] <= push_pc;
		end
	end
endmodule
`default_nettype wire

/* File: bps_pipe_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// Integer pipe model: hands back branch outcomes
// ----
module bps_pipe_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire bps_pkg::bps_res_s cmd,
	input wire logic [1:0] lat,
	output var bps_pkg::bps_res_s res
);
	logic pend_r;
	logic [1:0] cnt_r;
	bps_pkg::bps_res_s hold_r;

	// Outcome after lat extra cycles; idle fields toggle so stale data is never trusted
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 1'b0;
			cnt_r <= 2'd0;
			hold_r <= '0;
			res <= '0;
		end else begin
			res <= {1'b0, ~res[$bits(res)-2:0]};
			if (cmd.valid) begin
				pend_r <= 1'b1;
				cnt_r <= lat;
				hold_r <= cmd;
			end else if (pend_r && cnt_r == 2'd0) begin
				res <= hold_r;
				pend_r <= 1'b0;
			end else if (pend_r) begin
				cnt_r <= cnt_r - 2'd1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb_bps_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_bps_ctrl;
	localparam logic [31:0] PA = 32'h00001000;
	localparam logic [31:0] TA = 32'h00002000;
	localparam logic [31:0] PB = 32'h00001100;
	localparam logic [31:0] TB = 32'h00004000;
	localparam logic [31:0] PC = 32'h00003000;
	localparam logic [31:0] PD = 32'h00005010;
	localparam logic [31:0] PE = 32'h00003400;
	localparam logic [31:0] PF = 32'h00003800;
	logic core_clk;
	logic rst_n;
	bps_pkg::bps_fetch_s fetch_i;
	bps_pkg::bps_dec_s dec_i;
	bps_pkg::bps_res_s res_i;
	bps_pkg::bps_res_s cmd;
	logic [1:0] lat;
	logic fp_done;
	logic exc_fault;
	logic wbuf_full;
	logic [31:0] fetch_pc_r;
	logic [31:0] fetch_alt_pc_r;
	logic fetch_pred_taken_r, fetch_alt_vld_r, fetch_hold_r, issue_x_only_r, spec_stall_r;
	logic [2:0] spec_level_r;
	logic ckpt_save_r, restore_r, flush_r, br_ok_r, wr_hold_r;
	logic [1:0] ckpt_slot_r, restore_slot_r;
	int fail_count;
	int cmp_count;
	int cyc;

	bps_ctrl #(.LEVELS(4)) bps_ctrl_i (
		.core_clk(core_clk), .rst_n(rst_n), .fetch_i(fetch_i), .dec_i(dec_i),
		.res_i(res_i), .fp_done(fp_done), .exc_fault(exc_fault), .wbuf_full(wbuf_full),
		.fetch_pc_r(fetch_pc_r), .fetch_pred_taken_r(fetch_pred_taken_r),
		.fetch_alt_pc_r(fetch_alt_pc_r), .fetch_alt_vld_r(fetch_alt_vld_r),
		.fetch_hold_r(fetch_hold_r), .issue_x_only_r(issue_x_only_r),
		.spec_stall_r(spec_stall_r), .spec_level_r(spec_level_r),
		.ckpt_save_r(ckpt_save_r), .ckpt_slot_r(ckpt_slot_r), .restore_r(restore_r),
		.restore_slot_r(restore_slot_r), .flush_r(flush_r), .br_ok_r(br_ok_r),
		.wr_hold_r(wr_hold_r)
	);

	bps_pipe_model bps_pipe_model_i (
		.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .lat(lat), .res(res_i)
	);

	// 100 ns core clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Hang guard, far above the 120 or so cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			finish_test();
		end
	end

	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s: got %h want %h", $time, msg, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic fet(input logic [31:0] pc, input logic cond, call, ret);
		@(posedge core_clk);
		fetch_i <= '{1'b1, pc, pc + 32'h4, 1'b1, cond, call, ret};
		@(posedge core_clk);
		fetch_i <= '0;
		#1;
	endtask

	task automatic dec(input logic cbr, fp, nck, pt, input logic [31:0] ppc);
		@(posedge core_clk);
		dec_i <= '{1'b1, cbr, fp, nck, pt, ppc};
		@(posedge core_clk);
		dec_i <= '0;
		#1;
	endtask

	// Outcome goes through the pipe model; returns just after the design took it
	task automatic rsv(input logic tk, wb, input logic [31:0] pc, tgt, input logic [1:0] l);
		int n;
		@(posedge core_clk);
		cmd <= '{1'b1, tk, wb, pc, tgt, pc + 32'h4};
		lat <= l;
		@(posedge core_clk);
		cmd <= '0;
		#1;
		n = 0;
		while (res_i.valid !== 1'b1 && n < 8) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(n < 8, 1'b1, "pipe model silent");
		@(posedge core_clk);
		#1;
	endtask

	task automatic fpd();
		@(posedge core_clk);
		fp_done <= 1'b1;
		@(posedge core_clk);
		fp_done <= 1'b0;
		#1;
	endtask

	task automatic holdn(input int exp);
		int n;
		n = 0;
		while (fetch_hold_r === 1'b1 && n < 9) begin
			n++;
			@(posedge core_clk);
			#1;
		end
		chk(n, exp, "penalty cycles");
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_miss(input logic [31:0] pc, tgt, input logic pt, tk, wb, input logic [1:0] l);
		dec(1'b1, 1'b0, 1'b0, pt, pt ? tgt : pc + 32'h4);
		chk(wr_hold_r, 1'b1, "write hold");
		chk(issue_x_only_r, 1'b1, "primary pipe");
		rsv(tk, wb, pc, tgt, l);
		chk(flush_r, 1'b1, "flush");
		chk(restore_r, 1'b1, "restore");
		chk(fetch_pc_r, tk ? tgt : pc + 32'h4, "redirect");
		chk(spec_level_r, 3'd0, "level cleared");
		chk(br_ok_r, 1'b0, "no ok");
		holdn(wb ? bps_pkg::PEN_WB_CYC : bps_pkg::PEN_EX_CYC);
		chk(wr_hold_r, 1'b0, "hold released");
	endtask

	// Fill all levels with a branch and float mix, refuse one more, free two in order, then flush on a mispredict
	task automatic t_levels();
		for (int i = 0; i < 4; i++) begin
			dec(i[0] == 1'b0, i[0], 1'b0, 1'b0, PD + 32'h4);
			chk(ckpt_save_r, 1'b1, "save");
			chk(ckpt_slot_r, i[1:0], "slot order");
			chk(spec_level_r, i + 1, "level up");
			chk(issue_x_only_r, !i[0], "pipe steer");
		end
		dec(1'b0, 1'b1, 1'b0, 1'b0, PD + 32'h4);
		chk(ckpt_save_r, 1'b0, "fifth refused");
		chk(spec_stall_r, 1'b1, "stop");
		chk(spec_level_r, 3'd4, "level held");
		rsv(1'b0, 1'b0, PD, TB, 2'd2);
		chk(br_ok_r, 1'b1, "ok pulse");
		chk(restore_r, 1'b0, "no restore");
		chk(spec_level_r, 3'd3, "level down");
		fpd();
		chk(spec_level_r, 3'd2, "fp frees");
		rsv(1'b1, 1'b1, PD, TB, 2'd0);
		chk(restore_slot_r, 2'd2, "oldest restored");
		chk(spec_level_r, 3'd0, "cleared");
		holdn(bps_pkg::PEN_WB_CYC);
		fpd();
		chk(spec_level_r, 3'd0, "no underflow");
		rsv(1'b0, 1'b0, PD, TB, 2'd1);
		chk(br_ok_r, 1'b0, "ignored at zero");
	endtask

	task automatic t_stops();
		for (int k = 0; k < 3; k++) begin
			@(posedge core_clk);
			exc_fault <= (k == 0);
			wbuf_full <= (k == 1);
			dec(1'b1, 1'b0, k == 2, 1'b0, PA + 32'h4);
			chk(ckpt_save_r, 1'b0, "stop refuses");
			chk(spec_stall_r, 1'b1, "stop flag");
			chk(spec_level_r, 3'd0, "no level");
			@(posedge core_clk);
			exc_fault <= 1'b0;
			wbuf_full <= 1'b0;
		end
	endtask

	// Train, hit, weaken; then an unconditional hit
	task automatic t_pred();
		fet(PA, 1'b1, 1'b0, 1'b0);
		chk(fetch_pc_r, PA + 32'h4, "miss sequential");
		chk(fetch_pred_taken_r, 1'b0, "miss not taken");
		t_miss(PA, TA, 1'b0, 1'b1, 1'b0, 2'd0);
		fet(PA, 1'b1, 1'b0, 1'b0);
		chk(fetch_pc_r, TA, "hit target");
		chk(fetch_pred_taken_r, 1'b1, "hit taken");
		chk(fetch_alt_pc_r, PA + 32'h4, "alternate path");
		chk(fetch_alt_vld_r, 1'b1, "alternate valid");
		t_miss(PA, TA, 1'b1, 1'b0, 1'b1, 2'd3);
		fet(PA, 1'b1, 1'b0, 1'b0);
		chk(fetch_pred_taken_r, 1'b0, "counter weakened");
		chk(fetch_pc_r, PA + 32'h4, "weak path");
		t_miss(PB, TB, 1'b0, 1'b1, 1'b1, 2'd1);
		fet(PB, 1'b0, 1'b0, 1'b0);
		chk(fetch_pc_r, TB, "unconditional hit");
	endtask

	task automatic t_ras();
		fet(PC, 1'b0, 1'b1, 1'b0);
		fet(PE, 1'b0, 1'b1, 1'b0);
		fet(PF, 1'b0, 1'b0, 1'b1);
		chk(fetch_pc_r, PE + 32'h4, "inner return");
		fet(PF, 1'b0, 1'b0, 1'b1);
		chk(fetch_pc_r, PC + 32'h4, "outer return");
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		fetch_i = '0;
		dec_i = '0;
		cmd = '0;
		lat = 2'd0;
		fp_done = 1'b0;
		exc_fault = 1'b0;
		wbuf_full = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		chk(fetch_pc_r, bps_pkg::PC_RST, "reset fetch");
		chk(spec_level_r, 3'd0, "reset level");
		chk(wr_hold_r, 1'b0, "reset hold");
		t_levels();
		t_stops();
		t_pred();
		t_ras();
		finish_test();
	end
endmodule
`default_nettype wire
